/* rtl/emsp_defines.vh */
// Constants and behaviour summary for the external memory strobe pins
// How it works
// - Read strobe low during each external read, high otherwise when driven.
// - Data pins become inputs while read strobe is low; memory drives.
// - Data bus captured into a register at read strobe rising edge.
// - Low read strobe qualifies address, program, data and chip selects.
// - Idle read strobe floats or stays driven per idle drive control bit.
// - Write strobe low on writes; data pins drive the write data.
// - Low write strobe qualifies address and selects; feeds SRAM write enable.
// - Idle write strobe floats or stays driven per idle drive control bit.
// - Chip select zero is program select, low on program memory accesses.
// - Chip select zero floats when idle if drive control selects tristate.
// - Chip select zero resets into program select function, no setup.
// - Software should set idle drive control to one to keep pins driven.
// - Control pull-up disable bit switches off strobe pin pull-ups.
// - Program select pin may serve as port D bit eight GPIO.
// - Clearing port D pull-up bit eight drops program select pull-up.
// - Data memory select low on data accesses, qualified like program.
`ifndef EMSP_DEFINES_VH
`define EMSP_DEFINES_VH
// ----------------------------------------------------------------
// Widths and timing
// ----------------------------------------------------------------
`define EMSP_DATA_W 16
`define EMSP_ADDR_W 17
`define EMSP_NCS 4
`define EMSP_STROBE_CYC 3
`define EMSP_CNT_W 4
`define EMSP_PORTD_BIT 8
`define EMSP_IDLE_DRV_RST 1'b0
`endif

/* rtl/emsp_strobe_pins.v */
// External memory interface strobe, select and data pin logic
`timescale 1ns/100ps
`include "emsp_defines.vh"

module emsp_strobe_pins
#(
   parameter STROBE_CYC = `EMSP_STROBE_CYC
)
(
   input wire clock,
   input wire rstn,
   // Access request from the core
   input wire req_valid,
   input wire req_write,
   input wire req_program,
   input wire [`EMSP_NCS-1:0] req_cs_sel,
   input wire [`EMSP_ADDR_W-1:0] req_addr,
   input wire [`EMSP_DATA_W-1:0] req_wdata,
   output reg req_ready_r,
   output reg rdata_valid_r,
   output reg [`EMSP_DATA_W-1:0] rdata_r,
   // Control bits
   input wire idle_drive_control,
   input wire ctrl_pullup_disable,
   input wire port_d_pullup_bit_eight,
   input wire port_d_bit_eight_gpio_sel,
   input wire port_d_bit_eight_dir_out,
   input wire port_d_bit_eight_out,
   output reg port_d_bit_eight_in_r,
   // Pins
   output reg read_strobe_n_r,
   output reg read_strobe_oe_r,
   output reg write_strobe_n_r,
   output reg write_strobe_oe_r,
   output reg strobe_pullup_en_r,
   input wire program_select_in,
   output reg program_select_n_r,
   output reg program_select_oe_r,
   output reg program_select_pullup_en_r,
   output reg data_memory_select_n_r,
   output reg data_memory_select_oe_r,
   output reg [`EMSP_NCS-1:2] memory_chip_selects_n_r,
   output reg [`EMSP_ADDR_W-1:0] ext_address_bus_r,
   output reg ext_address_oe_r,
   input wire [`EMSP_DATA_W-1:0] ext_data_bus_in,
   output reg [`EMSP_DATA_W-1:0] ext_data_bus_out_r,
   output reg ext_data_bus_oe_r
);

// ----------------------------------------------------------------
// Access state machine
// ----------------------------------------------------------------
localparam ST_IDLE = 3'b001;
localparam ST_RD = 3'b010;
localparam ST_WR = 3'b100;
// Strobe length cut to the counter width on purpose
wire [31:0] last_cyc_full = STROBE_CYC - 1;
wire [`EMSP_CNT_W-1:0] last_cyc = last_cyc_full[`EMSP_CNT_W-1:0];

reg [2:0] state_r;
reg [2:0] state_nxt;
reg [`EMSP_CNT_W-1:0] cnt_r;
reg is_prog_r;
reg [`EMSP_NCS-1:0] cs_r;
reg ps_gpio_r;

wire done = (cnt_r == last_cyc);
wire start = req_valid && req_ready_r;

always @*
begin
   state_nxt = state_r;
   case (state_r)
      ST_IDLE:
      begin
         if (start)
            state_nxt = req_write ? ST_WR : ST_RD;
      end
      ST_RD:
      begin
         if (done)
            state_nxt = ST_IDLE;
      end
      ST_WR:
      begin
         if (done)
            state_nxt = ST_IDLE;
      end
      default:
         state_nxt = ST_IDLE;
   endcase
end

wire go_rd = (state_nxt == ST_RD);
wire go_wr = (state_nxt == ST_WR);
wire go_act = go_rd || go_wr;
// Pins held driven when bus active or drive control set
wire drive = go_act || idle_drive_control;

// ----------------------------------------------------------------
// Select decoding
// ----------------------------------------------------------------
// Space of the access: the new request wins over the one held
function sel_program;
   input take;
   input req_prog;
   input held_prog;
   begin
      sel_program = take ? req_prog : held_prog;
   end
endfunction

// Upper chip selects follow the request's select bits
wire [`EMSP_NCS-1:2] cs_hit;
genvar gi;

generate
   for (gi = 2; gi < `EMSP_NCS; gi = gi + 1)
   begin : g_cs_hit
      assign cs_hit[gi] = go_act && (start ? req_cs_sel[gi] : cs_r[gi]);
   end
endgenerate

// ----------------------------------------------------------------
// Sequencer registers
// ----------------------------------------------------------------
always @(posedge clock or negedge rstn)
begin
   if (!rstn)
   begin
      state_r <= ST_IDLE;
      cnt_r <= {`EMSP_CNT_W{1'b0}};
   end
   else
   begin
      state_r <= state_nxt;
      if ((state_r != state_nxt) || (state_r == ST_IDLE))
         cnt_r <= {`EMSP_CNT_W{1'b0}};
      else
         cnt_r <= cnt_r + 1'b1;
   end
end

// ----------------------------------------------------------------
// Request capture
// ----------------------------------------------------------------
// Address and write data held for the whole strobe window
always @(posedge clock or negedge rstn)
begin
   if (!rstn)
   begin
      req_ready_r <= 1'b0;
      is_prog_r <= 1'b1;
      cs_r <= {`EMSP_NCS{1'b0}};
      ext_address_bus_r <= {`EMSP_ADDR_W{1'b0}};
      ext_data_bus_out_r <= {`EMSP_DATA_W{1'b0}};
   end
   else
   begin
      req_ready_r <= (state_nxt == ST_IDLE) && !start;
      if (start)
      begin
         is_prog_r <= req_program;
         cs_r <= req_cs_sel;
         ext_address_bus_r <= req_addr;
         ext_data_bus_out_r <= req_wdata;
      end
   end
end

// Capture at strobe rising edge, the end of the read
always @(posedge clock or negedge rstn)
begin
   if (!rstn)
   begin
      rdata_valid_r <= 1'b0;
      rdata_r <= {`EMSP_DATA_W{1'b0}};
   end
   else
   begin
      rdata_valid_r <= (state_r == ST_RD) && done;
      if ((state_r == ST_RD) && done)
         rdata_r <= ext_data_bus_in;
   end
end

// ----------------------------------------------------------------
// Strobe pins
// ----------------------------------------------------------------
// Strobes exclusive: one-hot state decides
always @(posedge clock or negedge rstn)
begin
   if (!rstn)
   begin
      read_strobe_n_r <= 1'b1;
      write_strobe_n_r <= 1'b1;
   end
   else
   begin
      read_strobe_n_r <= !go_rd;
      write_strobe_n_r <= !go_wr;
   end
end

always @(posedge clock or negedge rstn)
begin
   if (!rstn)
   begin
      read_strobe_oe_r <= 1'b0;
      write_strobe_oe_r <= 1'b0;
      strobe_pullup_en_r <= 1'b1;
   end
   else
   begin
      read_strobe_oe_r <= drive;
      write_strobe_oe_r <= drive;
      strobe_pullup_en_r <= !ctrl_pullup_disable;
   end
end

// Data bus input while read, driven only while writing
always @(posedge clock or negedge rstn)
begin
   if (!rstn)
   begin
      ext_data_bus_oe_r <= 1'b0;
      ext_address_oe_r <= 1'b0;
   end
   else
   begin
      ext_data_bus_oe_r <= go_wr;
      ext_address_oe_r <= drive;
   end
end

// ----------------------------------------------------------------
// Select pins
// ----------------------------------------------------------------
// Pin function switch lags one cycle; no glitch mid-access intended
always @(posedge clock or negedge rstn)
begin
   if (!rstn)
   begin
      ps_gpio_r <= 1'b0;
      port_d_bit_eight_in_r <= 1'b0;
      program_select_pullup_en_r <= 1'b1;
   end
   else
   begin
      ps_gpio_r <= port_d_bit_eight_gpio_sel;
      port_d_bit_eight_in_r <= program_select_in;
      program_select_pullup_en_r <= port_d_pullup_bit_eight;
   end
end

// Selects asserted only inside a strobe window, save program select in GPIO use
always @(posedge clock or negedge rstn)
begin
   if (!rstn)
   begin
      program_select_n_r <= 1'b1;
      program_select_oe_r <= 1'b0;
   end
   else if (ps_gpio_r)
   begin
      program_select_n_r <= port_d_bit_eight_out;
      program_select_oe_r <= port_d_bit_eight_dir_out;
   end
   else
   begin
      program_select_n_r <= !(go_act &&
         sel_program(start, req_program, is_prog_r));
      program_select_oe_r <= drive;
   end
end

always @(posedge clock or negedge rstn)
begin
   if (!rstn)
   begin
      data_memory_select_n_r <= 1'b1;
      data_memory_select_oe_r <= 1'b0;
   end
   else
   begin
      data_memory_select_n_r <= !(go_act &&
         !sel_program(start, req_program, is_prog_r));
      data_memory_select_oe_r <= drive;
   end
end

// Upper chip selects always driven, high outside accesses
always @(posedge clock or negedge rstn)
begin
   if (!rstn)
   begin
      memory_chip_selects_n_r <= {(`EMSP_NCS-2){1'b1}};
   end
   else
   begin
      memory_chip_selects_n_r <= ~cs_hit;
   end
end

endmodule // emsp_strobe_pins

/* tb/emsp_mem_model.sv */
// Behavioural static memory on the far side of the strobe pins
`timescale 1ns/100ps
module emsp_mem_model (
   input wire clock,
   input wire oe_n,
   input wire we_n,
   input wire [16:0] addr,
   input wire [15:0] dq_in,
   output wire [15:0] dq_out,
   output wire dq_drive
);
   reg [15:0] mem [0:15];
   assign dq_drive = !oe_n;
   assign dq_out = mem[addr[3:0]];
   // Last word before the strobe rises is the one kept
   always @(posedge clock)
      if (!we_n)
         mem[addr[3:0]] <= dq_in;
endmodule // emsp_mem_model

/* tb/emsp_strobe_pins_monitor.sv */
// Concurrent checks on the strobe pin block ports
`timescale 1ns/100ps
module emsp_strobe_pins_monitor (
   input wire clock, rstn, req_valid, req_write, req_program, req_ready_r,
   input wire rdata_valid_r, idle_drive_control, ctrl_pullup_disable,
   input wire read_strobe_n_r, read_strobe_oe_r, write_strobe_n_r,
   input wire write_strobe_oe_r, strobe_pullup_en_r, data_memory_select_n_r,
   input wire ext_address_oe_r, ext_data_bus_oe_r,
   input wire [15:0] req_wdata, rdata_r, ext_data_bus_in, ext_data_bus_out_r
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   sequence s_take; req_valid && req_ready_r; endsequence
   property p_excl; !(!read_strobe_n_r && !write_strobe_n_r); endproperty
   a_excl: assert property (p_excl) else $error("strobes overlap");
   property p_dbus; ext_data_bus_oe_r |-> !write_strobe_n_r; endproperty
   a_dbus: assert property (p_dbus) else $error("bus driven");
   property p_rq; !read_strobe_n_r |-> read_strobe_oe_r && ext_address_oe_r;
   endproperty
   a_rq: assert property (p_rq) else $error("read unqualified");
   property p_wq; !write_strobe_n_r |-> ext_data_bus_oe_r && ext_address_oe_r;
   endproperty
   a_wq: assert property (p_wq) else $error("write undriven");
   property p_rgo; s_take ##0 !req_write |=> !read_strobe_n_r &&
      data_memory_select_n_r == $past(req_program) ##1 (!read_strobe_n_r)[*2]
      ##1 read_strobe_n_r && rdata_valid_r; endproperty
   a_rgo: assert property (p_rgo) else $error("read cycle");
   property p_wgo; s_take ##0 req_write |=> !write_strobe_n_r &&
      ext_data_bus_out_r == $past(req_wdata) ##1 $stable(ext_data_bus_out_r)[*3];
   endproperty
   a_wgo: assert property (p_wgo) else $error("write data");
   property p_cap; $rose(read_strobe_n_r) |-> rdata_r == $past(ext_data_bus_in);
   endproperty
   a_cap: assert property (p_cap) else $error("read capture");
   property p_idle; req_ready_r && $past(req_ready_r) |-> write_strobe_oe_r ==
      read_strobe_oe_r && read_strobe_oe_r == $past(idle_drive_control);
   endproperty
   a_idle: assert property (p_idle) else $error("idle oe");
   property p_pull; strobe_pullup_en_r == !$past(ctrl_pullup_disable);
   endproperty
   a_pull: assert property (p_pull) else $error("pull-up");
endmodule // emsp_strobe_pins_monitor
bind emsp_strobe_pins emsp_strobe_pins_monitor u_emsp_strobe_pins_monitor (.*);

/* tb/emsp_strobe_pins_bench.sv */
// Self-checking bench for the strobe pin block
`timescale 1ns/100ps
module emsp_strobe_pins_bench;
   reg clock = 0, rstn = 0, req_valid = 0, req_write = 0, req_program = 0;
   reg idle_drive_control = 0, ctrl_pullup_disable = 0, program_select_in = 0;
   reg port_d_pullup_bit_eight = 1, port_d_bit_eight_gpio_sel = 0;
   reg port_d_bit_eight_dir_out = 0, port_d_bit_eight_out = 0;
   reg [3:0] req_cs_sel = 4'h4;
   reg [16:0] req_addr = 0;
   reg [15:0] req_wdata = 0;
   wire req_ready_r, rdata_valid_r, port_d_bit_eight_in_r, read_strobe_n_r;
   wire read_strobe_oe_r, write_strobe_n_r, write_strobe_oe_r, dq_drive;
   wire strobe_pullup_en_r, program_select_n_r, program_select_oe_r;
   wire program_select_pullup_en_r, data_memory_select_n_r;
   wire data_memory_select_oe_r, ext_address_oe_r, ext_data_bus_oe_r;
   wire [3:2] memory_chip_selects_n_r;
   wire [16:0] ext_address_bus_r;
   wire [15:0] rdata_r, ext_data_bus_out_r, ext_data_bus_in, dq_out;
   integer n_fail = 0, total_checks = 0, cyc = 0;
   // Released data pins rest high on their pull-ups
   assign ext_data_bus_in = ext_data_bus_oe_r ? ext_data_bus_out_r :
      dq_drive ? dq_out : 16'hFFFF;
   emsp_strobe_pins u_emsp_strobe_pins (.*);
   emsp_mem_model u_emsp_mem_model (.clock(clock), .oe_n(read_strobe_n_r),
      .we_n(write_strobe_n_r), .addr(ext_address_bus_r),
      .dq_in(ext_data_bus_in), .dq_out(dq_out), .dq_drive(dq_drive));
   initial forever #5 clock = !clock;
   always @(posedge clock)
   begin
      cyc = cyc + 1;
      if (cyc == 400)
      begin
         n_fail = n_fail + 1;
         finish_test;
      end
   end
   task chk(input [31:0] got, input [31:0] exp);
   begin
      total_checks = total_checks + 1;
      if (got !== exp)
      begin
         n_fail = n_fail + 1;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   end
   endtask
   // Called at a falling edge; read expects d back
   task acc(input w, input p, input [16:0] a, input [15:0] d);
   begin
      {req_write, req_program, req_addr, req_wdata, req_valid} = {w, p, a, d, 1'b1};
      while (req_ready_r !== 1'b1)
         @(negedge clock);
      @(negedge clock);
      req_valid = 0;
      chk({read_strobe_n_r, write_strobe_n_r, program_select_n_r,
         data_memory_select_n_r, memory_chip_selects_n_r, ext_data_bus_oe_r},
         {w, !w, !p, p, 2'b10, w});
      repeat (3) @(negedge clock);
      if (!w)
         chk(rdata_r, d);
   end
   endtask
   task finish_test;
   begin
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   end
   endtask
   initial
   begin
      repeat (4) @(negedge clock);
      chk({read_strobe_oe_r, write_strobe_oe_r, program_select_oe_r,
         strobe_pullup_en_r, program_select_pullup_en_r, read_strobe_n_r,
         write_strobe_n_r, program_select_n_r}, 8'h1F);
      rstn = 1;
      repeat (3) @(negedge clock);
      chk({read_strobe_oe_r, write_strobe_oe_r, program_select_oe_r,
         data_memory_select_oe_r, ext_address_oe_r}, 0);
      acc(1, 1, 17'h00003, 16'hA5C3);
      idle_drive_control = 1;
      acc(1, 0, 17'h1000C, 16'h5A3C);
      acc(0, 1, 17'h00003, 16'hA5C3);
      acc(0, 0, 17'h1000C, 16'h5A3C);
      repeat (2) @(negedge clock);
      chk({read_strobe_oe_r, write_strobe_oe_r, program_select_oe_r,
         data_memory_select_oe_r, ext_address_oe_r}, 5'h1F);
      {ctrl_pullup_disable, port_d_pullup_bit_eight} = 2'b10;
      {port_d_bit_eight_gpio_sel, port_d_bit_eight_dir_out} = 2'b11;
      program_select_in = 1;
      repeat (2) @(negedge clock);
      chk({strobe_pullup_en_r, program_select_pullup_en_r, program_select_n_r,
         program_select_oe_r, port_d_bit_eight_in_r}, 5'h03);
      finish_test;
   end
endmodule // emsp_strobe_pins_bench
